/* File: rtl/bil_boot_loader.sv */
// boot sequencer: reset hold, source select, image load, check, start
//
// Contract
// - stay in reset while reset pin low
// - pull-downs on all pins during reset
// - wait 15 us after release before booting
// - secure-boot bit 5 set: boot from OTP
// - secure-boot bit clear: boot from flash
// - flash reached through tile 0 ports
// - image: size word, s*4 bytes, check word
// - size and check words least byte first
// - program bytes written from lowest RAM address
// - execution starts at lowest RAM address
// - bypass marker skips the checksum test
// - checksum covers size word and program bytes
// - reflected CRC-32, lsb first
// - accumulator preset to all ones
// - inverted accumulator compared to check word
// - secure boot reads OTP from address 0
// - security word fetched from OTP first
`timescale 1ns/10ps
`default_nettype none
module bil_boot_loader #(
  parameter int AW = 16 // ram word address width
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic rst_pin_n,
  output logic otp_rd,
  output logic [10:0] otp_addr,
  input wire logic [31:0] otp_rdata,
  input wire logic otp_rvalid,
  output logic flash_sck,
  output logic flash_cs_n,
  output logic flash_mosi,
  input wire logic flash_miso,
  output logic ram_we,
  output logic [AW-1:0] ram_addr,
  output logic [31:0] ram_wdata,
  output logic gpio_pd_en,
  output logic core_run,
  output logic [AW-1:0] run_addr,
  output logic boot_err,
  output logic boot_src_otp
);
  typedef enum logic [8:0] {
    ST_HOLD = 9'h001,
    ST_DELAY = 9'h002,
    ST_SEC = 9'h004,
    ST_SIZE = 9'h008,
    ST_PROG = 9'h010,
    ST_CHECK = 9'h020,
    ST_VERIFY = 9'h040,
    ST_RUN = 9'h080,
    ST_ERR = 9'h100
  } bil_state_t;

  localparam logic [AW-1:0] RUN_ADDR = '0; // lowest ram word

  bil_state_t st_r;        // sequencer state
  bil_state_t st_nxt;      // next state
  logic rs1_r, rs2_r;      // reset pin synchroniser
  logic [bil_pkg::DLY_W-1:0] dly_r; // boot wait counter
  logic [31:0] sec_r;      // security register copy
  logic busy_r;            // otp read outstanding
  logic [10:0] oaddr_r;    // otp row to read next
  logic [31:0] ow_r;       // otp word being unpacked
  logic [1:0] oidx_r;      // byte index in otp word
  logic ohave_r;           // otp word has bytes left
  logic [1:0] bcnt_r;      // bytes of current word
  logic [31:0] asm_r;      // word assembly
  logic [31:0] left_r;     // program words remaining
  logic [31:0] chk_r;      // received check word
  logic [AW-1:0] widx_r;   // next ram word
  logic we_r;              // ram write strobe
  logic [AW-1:0] wa_r;     // ram write address
  logic [31:0] wd_r;       // ram write data
  logic [31:0] crc_q;      // running accumulator

  bil_byte_if bs ();

  // flash on the tile 0 serial ports
  bil_flash_rd u_flash (
    .clk(clk),
    .rst(rst),
    .bs(bs.src),
    .sck(flash_sck),
    .cs_n(flash_cs_n),
    .mosi(flash_mosi),
    .miso_pin(flash_miso)
  );

  // decode and byte source selection
  wire logic pin_low = !rs2_r;
  wire logic sec_boot = sec_r[bil_pkg::SEC_BOOT_BIT];
  wire logic ld = (st_r == ST_SIZE) || (st_r == ST_PROG) || (st_r == ST_CHECK);
  wire logic rd_go = !busy_r && ((st_r == ST_SEC) || (ld && sec_boot && !ohave_r));
  wire logic otp_byte = ld && sec_boot && ohave_r;
  wire logic b_vld = sec_boot ? otp_byte : (ld && bs.vld);
  wire logic [7:0] b_dat = sec_boot ? ow_r[{oidx_r, 3'h0} +: 8] : bs.dat;
  wire logic [31:0] asm_nxt = {b_dat, asm_r[31:8]};
  wire logic word_done = b_vld && (bcnt_r == 2'h3);
  wire logic crc_upd = b_vld && ((st_r == ST_SIZE) || (st_r == ST_PROG));
  wire logic bypass = (chk_r == bil_pkg::BYPASS_WORD);
  wire logic crc_ok = (~crc_q == chk_r);

  assign bs.en = ld && !sec_boot;

  bil_crc u_crc (
    .clk(clk),
    .rst(rst),
    .init(st_r == ST_DELAY),
    .upd(crc_upd),
    .dat(b_dat),
    .crc(crc_q)
  );

  // reset pin passes two flops before use
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rs1_r <= 1'b0;
      rs2_r <= 1'b0;
    end else begin
      rs1_r <= rst_pin_n;
      rs2_r <= rs1_r;
    end
  end

  // next state
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      ST_HOLD: begin
        st_nxt = ST_DELAY;
      end
      ST_DELAY: begin
        if (dly_r == bil_pkg::DLY_W'(bil_pkg::DLY_CYC - 1)) begin
          st_nxt = ST_SEC;
        end
      end
      ST_SEC: begin
        if (otp_rvalid) begin
          st_nxt = ST_SIZE;
        end
      end
      ST_SIZE: begin
        if (word_done) begin
          st_nxt = (asm_nxt == 32'h0) ? ST_CHECK : ST_PROG;
        end
      end
      ST_PROG: begin
        if (word_done && left_r == 32'h1) begin
          st_nxt = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if (word_done) begin
          st_nxt = ST_VERIFY;
        end
      end
      ST_VERIFY: begin
        st_nxt = (bypass || crc_ok) ? ST_RUN : ST_ERR;
      end
      ST_RUN: begin
        st_nxt = ST_RUN;
      end
      ST_ERR: begin
        st_nxt = ST_ERR;
      end
      default: begin
        st_nxt = ST_HOLD;
      end
    endcase
    if (pin_low) begin
      st_nxt = ST_HOLD;
    end
  end

  // state and boot wait
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= ST_HOLD;
      dly_r <= '0;
    end else begin
      st_r <= st_nxt;
      dly_r <= (st_r == ST_DELAY) ? dly_r + bil_pkg::DLY_W'(1) : '0;
    end
  end

  // otp reads: security word first, then image rows
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_r <= 1'b0;
      oaddr_r <= bil_pkg::OTP_SEC_ADDR;
      sec_r <= bil_pkg::SEC_RST;
      ow_r <= 32'h0;
      oidx_r <= 2'h0;
      ohave_r <= 1'b0;
    end else if (st_r == ST_HOLD) begin
      busy_r <= 1'b0;
      oaddr_r <= bil_pkg::OTP_SEC_ADDR;
      ohave_r <= 1'b0;
    end else begin
      if (rd_go) begin
        busy_r <= 1'b1;
      end else if (otp_rvalid) begin
        busy_r <= 1'b0;
      end
      if (otp_rvalid && st_r == ST_SEC) begin
        sec_r <= otp_rdata;
        oaddr_r <= bil_pkg::OTP_IMG_BASE;
      end else if (otp_rvalid && ld) begin
        ow_r <= otp_rdata;
        oidx_r <= 2'h0;
        ohave_r <= 1'b1;
        oaddr_r <= oaddr_r + 11'h1;
      end else if (otp_byte) begin
        oidx_r <= oidx_r + 2'h1; // low byte first
        ohave_r <= (oidx_r != 2'h3);
      end
    end
  end

  // word assembly, size, program writes and check word
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bcnt_r <= 2'h0;
      asm_r <= 32'h0;
      left_r <= 32'h0;
      chk_r <= 32'h0;
      widx_r <= '0;
      we_r <= 1'b0;
      wa_r <= '0;
      wd_r <= 32'h0;
    end else begin
      we_r <= 1'b0;
      if (st_r == ST_HOLD) begin
        bcnt_r <= 2'h0;
        widx_r <= RUN_ADDR;
      end else if (b_vld) begin
        bcnt_r <= bcnt_r + 2'h1;
        asm_r <= asm_nxt;
        if (word_done && st_r == ST_SIZE) begin
          left_r <= asm_nxt;
        end
        if (word_done && st_r == ST_PROG) begin
          we_r <= 1'b1;
          wa_r <= widx_r;
          wd_r <= asm_nxt;
          widx_r <= widx_r + AW'(1);
          left_r <= left_r - 32'h1;
        end
        if (word_done && st_r == ST_CHECK) begin
          chk_r <= asm_nxt;
        end
      end
    end
  end

  assign otp_rd = rd_go;
  assign otp_addr = oaddr_r;
  assign ram_we = we_r;
  assign ram_addr = wa_r;
  assign ram_wdata = wd_r;
  assign gpio_pd_en = (st_r == ST_HOLD);
  assign core_run = (st_r == ST_RUN);
  assign run_addr = RUN_ADDR;
  assign boot_err = (st_r == ST_ERR);
  assign boot_src_otp = sec_boot;

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  property p_hold;
    pin_low |=> st_r == ST_HOLD;
  endproperty
  a_hold: assert property (p_hold) else $error("reset pin low but not held");

  property p_pd;
    pin_low |=> gpio_pd_en && !core_run;
  endproperty
  a_pd: assert property (p_pd) else $error("pull-downs off during reset");

  property p_dly;
    $rose(st_r == ST_SEC) |-> $past(dly_r) == bil_pkg::DLY_W'(bil_pkg::DLY_CYC - 1);
  endproperty
  a_dly: assert property (p_dly) else $error("boot wait length wrong");

  property p_otp_src;
    (ld && sec_boot) |-> flash_cs_n && !flash_sck;
  endproperty
  a_otp_src: assert property (p_otp_src) else $error("flash used in secure boot");

  property p_otp_base;
    $rose(st_r == ST_SIZE) && sec_boot |-> otp_addr == bil_pkg::OTP_IMG_BASE;
  endproperty
  a_otp_base: assert property (p_otp_base) else $error("otp image not at zero");

  property p_first;
    $rose(st_r == ST_PROG) |-> widx_r == RUN_ADDR;
  endproperty
  a_first: assert property (p_first) else $error("load not at lowest word");

  property p_run;
    $rose(core_run) |-> $past(st_r == ST_VERIFY) && run_addr == RUN_ADDR;
  endproperty
  a_run: assert property (p_run) else $error("start without verify");

  property p_bypass;
    (st_r == ST_VERIFY && bypass && !pin_low) |=> core_run;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass marker not honoured");

  property p_bad;
    (st_r == ST_VERIFY && !bypass && !crc_ok && !pin_low) |=> boot_err ##1 !core_run;
  endproperty
  a_bad: assert property (p_bad) else $error("bad checksum not flagged");

  property p_stop;
    (st_r == ST_CHECK && word_done) |=> !bs.en;
  endproperty
  a_stop: assert property (p_stop) else $error("flash read past check word");

  c_run_flash: cover property (core_run && !sec_boot);
  c_run_otp: cover property (core_run && sec_boot);
  c_err: cover property (boot_err);
  c_bypass: cover property (st_r == ST_VERIFY && bypass);
endmodule
`default_nettype wire

/* File: rtl/bil_pkg.sv */
// constants shared by the boot image loader files
package bil_pkg;
  localparam int CLK_MHZ = 125;               // core clock rate
  localparam int BOOT_DLY_NS = 15000;         // least wait before boot, ns
  localparam int DLY_CYC = (BOOT_DLY_NS * CLK_MHZ + 999) / 1000; // rounded up
  localparam int DLY_W = 12;                  // width of the wait counter
  localparam int SEC_BOOT_BIT = 5;            // secure-boot bit position
  localparam logic [31:0] SEC_RST = 32'h0000_0000;   // security reg at reset
  localparam logic [31:0] BYPASS_WORD = 32'h0d15_ab1e; // skip-check marker
  localparam logic [31:0] CRC_POLY = 32'hedb8_8320;   // reflected polynomial
  localparam logic [31:0] CRC_PRESET = 32'hffff_ffff; // accumulator preset
  localparam logic [10:0] OTP_IMG_BASE = 11'h000;     // image start row
  localparam logic [10:0] OTP_SEC_ADDR = 11'h7ff;     // security word row
  localparam logic [7:0] SPI_READ_CMD = 8'h03;        // serial read command
  localparam logic [23:0] FLASH_START = 24'h00_0000;  // first flash address
  localparam int SPI_HALF = 4;                // clocks per half serial clock
endpackage

/* File: rtl/bil_byte_if.sv */
// byte stream carrier between the flash reader and the loader
`timescale 1ns/10ps
`default_nettype none
interface bil_byte_if;
  logic en;        // loader wants bytes
  logic vld;       // one-cycle byte strobe
  logic [7:0] dat; // byte, held until the next strobe
  modport src (input en, output vld, output dat);
  modport snk (output en, input vld, input dat);
endinterface
`default_nettype wire

/* File: rtl/bil_crc.sv */
// byte-wide reflected crc accumulator
`timescale 1ns/10ps
`default_nettype none
module bil_crc (
  input wire logic clk,
  input wire logic rst,
  input wire logic init,
  input wire logic upd,
  input wire logic [7:0] dat,
  output logic [31:0] crc
);
  // eight lsb-first steps of the reflected polynomial
  function automatic logic [31:0] bil_step(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r >> 1) ^ (bil_pkg::CRC_POLY & {32{r[0] ^ d[i]}});
    end
    return r;
  endfunction

  logic [31:0] crc_r; // running accumulator
  wire logic [31:0] crc_nxt = bil_step(crc_r, dat);

  // preset, then fold in each accepted byte
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      crc_r <= bil_pkg::CRC_PRESET;
    end else if (init) begin
      crc_r <= bil_pkg::CRC_PRESET;
    end else if (upd) begin
      crc_r <= crc_nxt;
    end
  end
  assign crc = crc_r;
endmodule
`default_nettype wire

/* File: rtl/bil_flash_rd.sv */
// serial flash reader: read command at address zero, then byte stream
`timescale 1ns/10ps
`default_nettype none
module bil_flash_rd #(
  parameter int HALF = bil_pkg::SPI_HALF
) (
  input wire logic clk,
  input wire logic rst,
  bil_byte_if.src bs,
  output logic sck,
  output logic cs_n,
  output logic mosi,
  input wire logic miso_pin
);
  typedef enum logic [2:0] {FL_IDLE = 3'h1, FL_CMD = 3'h2, FL_DATA = 3'h4} bil_fl_t;
  bil_fl_t st_r;          // reader state
  logic [7:0] div_r;      // half-period divider
  logic sck_r;            // serial clock level
  logic [31:0] sh_r;      // command and address shifter
  logic [4:0] bit_r;      // rising edges in current phase
  logic [6:0] rx_r;       // bits of the byte in flight
  logic [7:0] dat_r;      // last complete byte
  logic vld_r;            // byte strobe
  logic m1_r, m2_r;       // miso synchroniser

  wire logic tick = (div_r == 8'(HALF - 1));
  wire logic rise = tick && !sck_r && (st_r != FL_IDLE);
  wire logic fall = tick && sck_r;

  // two flops before the data pin is read
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      m1_r <= 1'b0;
      m2_r <= 1'b0;
    end else begin
      m1_r <= miso_pin;
      m2_r <= m1_r;
    end
  end

  // divider and clock level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_r <= 8'h00;
      sck_r <= 1'b0;
    end else if (st_r == FL_IDLE || !bs.en) begin
      div_r <= 8'h00;
      sck_r <= 1'b0;
    end else begin
      div_r <= tick ? 8'h00 : div_r + 8'h01;
      if (tick) begin
        sck_r <= !sck_r;
      end
    end
  end

  // sequence: command out on falling edges, data in on rising edges
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= FL_IDLE;
      sh_r <= 32'h0000_0000;
      bit_r <= 5'h00;
      rx_r <= 7'h00;
      dat_r <= 8'h00;
      vld_r <= 1'b0;
    end else begin
      vld_r <= 1'b0;
      if (!bs.en) begin
        st_r <= FL_IDLE; // frame ends when the loader stops asking
      end else if (st_r == FL_IDLE) begin
        st_r <= FL_CMD;
        sh_r <= {bil_pkg::SPI_READ_CMD, bil_pkg::FLASH_START};
        bit_r <= 5'h00;
      end else if (rise) begin
        bit_r <= bit_r + 5'h01;
        rx_r <= {rx_r[5:0], m2_r};
        if (st_r == FL_CMD && bit_r == 5'h1f) begin
          st_r <= FL_DATA;
          bit_r <= 5'h00;
        end else if (st_r == FL_DATA && bit_r[2:0] == 3'h7) begin
          dat_r <= {rx_r[6:0], m2_r}; // msb first on the wire
          vld_r <= 1'b1;
        end
      end else if (fall && st_r == FL_CMD) begin
        sh_r <= {sh_r[30:0], 1'b0};
      end
    end
  end

  assign sck = sck_r;
  assign cs_n = (st_r == FL_IDLE);
  assign mosi = sh_r[31];
  assign bs.vld = vld_r;
  assign bs.dat = dat_r;
endmodule
`default_nettype wire

/* File: verification/bil_flash_model.sv */
// serial flash model: takes a read command, then streams image bytes msb first
`timescale 1ns/10ps
`default_nettype none
module bil_flash_model (
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso
);
  logic [7:0] mem [0:63]; // image bytes, loaded by the bench
  logic [31:0] cmd_r; // command and address shifted in
  logic [7:0] cur; // byte being sent
  int cnt; // rising serial edges since select
  int pos; // stream bit index
  initial begin
    miso = 1'b0;
    cmd_r = '0;
    cnt = 0;
  end
  // select ends: line released, so show the inverse of the last bit
  always @(posedge cs_n) begin
    miso <= ~miso;
  end
  // new frame restarts the bit count
  always @(negedge cs_n) begin
    cnt = 0;
  end
  // rising serial clock: shift in command and address bits
  always @(posedge sck) begin
    if (!cs_n) begin
      if (cnt < 32) begin
        cmd_r = {cmd_r[30:0], mosi};
      end
      cnt = cnt + 1;
    end
  end
  // falling serial clock: next data bit, or a changing pattern before data
  always @(negedge sck) begin
    if (!cs_n && cnt >= 32) begin
      pos = cnt - 32;
      cur = mem[pos >> 3];
      miso <= cur[7 - (pos & 7)];
    end else begin
      miso <= ~miso;
    end
  end
endmodule
`default_nettype wire

/* File: verification/test_bil_boot_loader.sv */
// self-checking bench for the boot image loader
`timescale 1ns/10ps
`default_nettype none
module test_bil_boot_loader;
  localparam int AW = 16; // ram word address width
  localparam int LIMIT = 60000; // cycle ceiling for the whole run
  typedef struct packed {
    logic src_otp; // image in otp rather than flash
    logic [3:0] size; // program words
    logic [1:0] kind; // 0 good, 1 bypass, 2 bad, 3 uninverted check word
    logic run; // execution expected
  } bil_row_t;
  logic clk, rst, rst_pin_n, otp_rd, otp_rvalid, ram_we, gpio_pd_en;
  logic flash_sck, flash_cs_n, flash_mosi, flash_miso, core_run, boot_err, boot_src_otp;
  logic [10:0] otp_addr;
  logic [31:0] otp_rdata, ram_wdata;
  logic [AW-1:0] ram_addr, run_addr;
  logic [31:0] otp_mem [0:2047]; // otp contents
  logic [31:0] img [0:17]; // size, program, check word
  logic [31:0] wq[$]; // ram words seen
  logic [AW-1:0] aq[$]; // ram addresses seen
  logic [10:0] oq[$]; // otp rows requested
  logic [10:0] rd_row; // row of the outstanding otp read
  int n_fail, checks_done, cyc, cs_cyc, t_rel, t_req, lat;
  bil_row_t rows [0:6] = '{'{1'b0, 4'h2, 2'h0, 1'b1}, '{1'b0, 4'h0, 2'h1, 1'b1},
    '{1'b0, 4'h1, 2'h2, 1'b0}, '{1'b0, 4'h3, 2'h3, 1'b0}, '{1'b1, 4'h2, 2'h0, 1'b1},
    '{1'b1, 4'h1, 2'h1, 1'b1}, '{1'b1, 4'h0, 2'h2, 1'b0}};
  bil_boot_loader #(.AW(AW)) i_bil_boot_loader (.clk(clk), .rst(rst), .rst_pin_n(rst_pin_n),
    .otp_rd(otp_rd), .otp_addr(otp_addr), .otp_rdata(otp_rdata), .otp_rvalid(otp_rvalid),
    .flash_sck(flash_sck), .flash_cs_n(flash_cs_n), .flash_mosi(flash_mosi),
    .flash_miso(flash_miso), .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
    .gpio_pd_en(gpio_pd_en), .core_run(core_run), .run_addr(run_addr),
    .boot_err(boot_err), .boot_src_otp(boot_src_otp));
  bil_flash_model i_bil_flash_model (.sck(flash_sck), .cs_n(flash_cs_n), .mosi(flash_mosi),
    .miso(flash_miso));
  // core clock, 8 ns period
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  // verdict and end of run
  task automatic tally_and_finish();
    begin
      if (n_fail == 0 && checks_done > 0) begin
        $display("All tests passed");
      end else begin
        $display("Some tests failed");
      end
      $finish;
    end
  endtask
  // reflected crc over one word, bytes and bits lsb first
  function automatic logic [31:0] crc_word(input logic [31:0] c, input logic [31:0] w);
    for (int b = 0; b < 32; b++) begin
      c = (c[0] ^ w[b]) ? ((c >> 1) ^ 32'hedb8_8320) : (c >> 1);
    end
    return c;
  endfunction
  // monitors: ram writes, otp requests, flash select time, timeout
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (otp_rd) begin
      oq.push_back(otp_addr);
      rd_row <= otp_addr;
      lat <= 3;
    end
    if (otp_rd && t_req < 0) begin
      t_req <= cyc;
    end
    if (ram_we) begin
      wq.push_back(ram_wdata);
      aq.push_back(ram_addr);
    end
    if (!flash_cs_n) begin
      cs_cyc <= cs_cyc + 1;
    end
    if (cyc == LIMIT) begin
      n_fail = n_fail + 1;
      tally_and_finish();
    end
  end
  // otp answers a few cycles later; between answers the data lines churn
  always @(negedge clk) begin
    otp_rvalid <= (lat == 1);
    otp_rdata <= (lat == 1) ? otp_mem[rd_row] : ~otp_rdata;
    if (lat > 0) begin
      lat <= lat - 1;
    end
  end
  // build the image in otp and flash
  task automatic load(input bil_row_t r);
    logic [31:0] crc;
    int n;
    begin
      n = r.size;
      img[0] = 32'(n);
      crc = crc_word(32'hffff_ffff, img[0]);
      for (int i = 1; i <= n; i++) begin
        img[i] = 32'hc3a5_0f1e ^ (i * 32'h0104_1009);
        crc = crc_word(crc, img[i]);
      end
      case (r.kind)
        2'h0: img[n + 1] = ~crc;
        2'h1: img[n + 1] = 32'h0d15_ab1e;
        2'h2: img[n + 1] = ~crc ^ 32'h0000_0001;
        default: img[n + 1] = crc;
      endcase
      for (int k = 0; k < 16; k++) begin
        otp_mem[k] = (k <= n + 1) ? img[k] : 32'h5a5a_5a5a;
        for (int j = 0; j < 4; j++) begin
          i_bil_flash_model.mem[4 * k + j] = (k <= n + 1) ? img[k][8 * j +: 8] : 8'h5a;
        end
      end
      // every bit differs between the two settings; the secure-boot bit is set only for otp
      otp_mem[11'h7ff] = r.src_otp ? 32'h0000_0020 : 32'hffff_ffdf;
    end
  endtask
  // hold the reset pin low, then release it
  task automatic pin_pulse();
    begin
      @(negedge clk);
      rst_pin_n = 1'b0;
      repeat (8) @(negedge clk);
      chk("pd_hold", 32'(gpio_pd_en), 32'h1);
      chk("run_hold", 32'(core_run), 32'h0);
      wq.delete();
      aq.delete();
      oq.delete();
      cs_cyc = 0;
      t_req = -1;
      rst_pin_n = 1'b1;
      t_rel = cyc;
    end
  endtask
  // one boot from start to verdict
  task automatic run_row(input bil_row_t r);
    int n;
    begin
      n = r.size;
      load(r);
      pin_pulse();
      for (int k = 0; k < 8000 && core_run !== 1'b1 && boot_err !== 1'b1; k++) begin
        @(negedge clk);
      end
      chk("core_run", 32'(core_run), 32'(r.run));
      chk("boot_err", 32'(boot_err), 32'(!r.run));
      chk("src_otp", 32'(boot_src_otp), 32'(r.src_otp));
      chk("pd_run", 32'(gpio_pd_en), 32'h0);
      chk("sec_row", 32'(oq[0]), 32'h7ff);
      chk("wait_ok", 32'((t_req - t_rel >= 1875) && (t_req - t_rel <= 18750)), 32'h1);
      if (r.src_otp) begin
        chk("img_row", 32'(oq[1]), 32'h0);
        chk("flash_idle", 32'(cs_cyc), 32'h0);
      end else begin
        chk("flash_cmd", i_bil_flash_model.cmd_r, 32'h0300_0000);
        chk("otp_reads", 32'(oq.size()), 32'h1);
      end
      chk("n_words", 32'(wq.size()), 32'(n));
      for (int i = 0; i < n; i++) begin
        chk("ram_addr", 32'(aq[i]), 32'(i));
        chk("ram_data", wq[i], img[i + 1]);
      end
      if (r.run) begin
        chk("run_addr", 32'(run_addr), 32'h0);
      end
    end
  endtask
  // main sequence
  initial begin
    rst = 1'b1;
    rst_pin_n = 1'b0;
    otp_rvalid = 1'b0;
    otp_rdata = 32'h0;
    n_fail = 0;
    checks_done = 0;
    cyc = 0;
    lat = 0;
    t_req = -1;
    repeat (4) @(negedge clk);
    chk("rst_pd", 32'(gpio_pd_en), 32'h1);
    chk("rst_cs", 32'(flash_cs_n), 32'h1);
    chk("rst_run", 32'(core_run), 32'h0);
    rst = 1'b0;
    for (int i = 0; i < 7; i++) begin
      run_row(rows[i]);
    end
    // pin pulled low in the middle of a flash load
    load(rows[3]);
    pin_pulse();
    for (int k = 0; k < 6000 && wq.size() == 0; k++) begin
      @(negedge clk);
    end
    rst_pin_n = 1'b0;
    repeat (6) @(negedge clk);
    chk("abort_pd", 32'(gpio_pd_en), 32'h1);
    chk("abort_cs", 32'(flash_cs_n), 32'h1);
    chk("abort_run", 32'(core_run | boot_err), 32'h0);
    run_row(rows[0]);
    tally_and_finish();
  end
endmodule
`default_nettype wire
